//--- verilog/scc_map.svh
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH
// ==========================================================================
// register addresses in the special function register space
`define SCC_ADDR_TRIM      8'h8b
`define SCC_ADDR_XCTL      8'h8c
`define SCC_ADDR_SEL       8'h97
`define SCC_ADDR_ICTL      8'h8a
`define SCC_ADDR_PLLST     8'h89
// ==========================================================================
// field positions
`define SCC_ICTL_ON_BIT    7
`define SCC_ICTL_RDY_BIT   6
`define SCC_XCTL_VLD_BIT   7
`define SCC_XCTL_RSV_BIT   3
`define SCC_PLLST_LCK_BIT  4
// ==========================================================================
// reset values
`define SCC_ICTL_RESET     8'hc0
`define SCC_XCTL_RESET     8'h00
`define SCC_SEL_RESET      8'h00
`define SCC_TRIM_RESET     8'h80
// ==========================================================================
// timing counts
`define SCC_IOSC_SETTLE    4
`define SCC_XTAL_SETTLE    16
`endif

//--- verilog/scc_pkg.sv
package scc_pkg;
    typedef enum logic [1:0] {
        SCC_SRC_INT = 2'b00,
        SCC_SRC_EXT = 2'b01,
        SCC_SRC_PLL = 2'b10,
        SCC_SRC_RSV = 2'b11
    } scc_src_t;

    typedef logic [2:0] scc_mode_t;
endpackage

//--- verilog/scc_div_if.sv
`timescale 1ns/1ns
interface scc_div_if #(parameter int W = 2);
    logic         in_tick;
    logic [W-1:0] shift;
    logic         out_tick;
    modport src (output in_tick, output shift, input out_tick);
    modport div (input in_tick, input shift, output out_tick);
endinterface : scc_div_if

//--- verilog/scc_clkdiv.sv
`timescale 1ns/1ns
// divides a tick stream by two to the power of shift
module scc_clkdiv #(
    parameter int MAXLOG = 3
) (
    input  wire logic CLK,
    input  wire logic RESET_N,
    scc_div_if.div    d
);
    logic [MAXLOG-1:0] cnt_r;
    logic [MAXLOG-1:0] cnt_nxt;
    logic [MAXLOG-1:0] limit;
    logic              out_r;
    logic              out_nxt;

    // ======================================================================
    // divider
    always_comb begin
        limit   = MAXLOG'((1 << d.shift) - 1);
        cnt_nxt = cnt_r;
        out_nxt = 1'b0;
        if (d.in_tick) begin
            // >= so a smaller ratio written mid-count takes effect at once
            if (cnt_r >= limit) begin
                cnt_nxt = '0;
                out_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            cnt_r <= '0;
            out_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
        end
    end

    assign d.out_tick = out_r;

    a_div_spacing: assert property (@(posedge CLK) disable iff (!RESET_N)
        (out_r && d.shift != '0 && $stable(d.shift)) |=> !out_r)
        else $error("divided tick repeated back to back");

    a_div_bypass: assert property (@(posedge CLK) disable iff (!RESET_N)
        (d.in_tick && d.shift == '0) |=> out_r)
        else $error("undivided tick lost");
endmodule : scc_clkdiv

//--- verilog/scc_top.sv
`timescale 1ns/1ns
`include "scc_map.svh"
// Summary of operation
// - an 8-bit trim register sets the internal oscillator period and resets to a calibrated value.
// - bit 7 of the internal oscillator control register turns the internal oscillator on or off.
// - read-only bit 6 reads 1 only while the internal oscillator runs at its set frequency.
// - the internal divider code 00/01/10/11 divides the internal oscillator by 8/4/2/1.
// - the source code 00/01/10 picks divided internal, external or PLL clock, and 11 is reserved.
// - the external oscillator keeps clocking peripherals whatever source drives the core.
// - enabling the internal oscillator and setting its divider may share one write.
// - read-only crystal valid bit 7 sets once the crystal settles and reads 0 outside modes 11x.
// - the PLL lock flag reads 1 once the PLL has locked.
// - the clock-out divider code 00/01/10/11 passes the core clock divided by 1/2/4/8.
// - the 3-bit external mode selects off, CMOS clock, halved CMOS, halved RC/C, crystal, halved.
// - the 3-bit drive range field is passed to the external oscillator driver.
// - bit 3 of the external oscillator control register reads 0 and ignores writes.
// - after reset the core runs from the internal oscillator with no software action.
module scc_top #(
    parameter logic [7:0] TRIM_RESET  = `SCC_TRIM_RESET,
    parameter int         IOSC_SETTLE = `SCC_IOSC_SETTLE,
    parameter int         XTAL_SETTLE = `SCC_XTAL_SETTLE
) (
    input  wire logic       CLK,
    input  wire logic       RESET_N,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic       SFR_WR,
    input  wire logic [7:0] SFR_WDATA,
    output logic      [7:0] SFR_RDATA,
    input  wire logic       EXT_OSC_TICK,
    input  wire logic       PLL_TICK,
    input  wire logic       PLL_LOCK,
    output logic      [7:0] INT_OSC_TRIM,
    output logic            INT_OSC_ON,
    output logic      [2:0] EXT_OSC_MODE,
    output logic      [2:0] EXT_DRIVE_RANGE,
    output logic            EXT_OSC_ON,
    output logic            CORE_CLK_EN,
    output logic            CLK_OUT_EN,
    output logic            EXT_PERIPH_EN,
    output logic      [1:0] CORE_CLK_SOURCE
);
    localparam int SW = $clog2(IOSC_SETTLE + 1);
    localparam int XW = $clog2(XTAL_SETTLE + 1);

    // ======================================================================
    // mode decode
    function automatic logic ext_on_f(input scc_pkg::scc_mode_t m);
        return m[2:1] != 2'b00;
    endfunction
    function automatic logic ext_half_f(input scc_pkg::scc_mode_t m);
        return (m == 3'b011) || (m[2:1] == 2'b10) || (m == 3'b111);
    endfunction
    function automatic logic crystal_f(input scc_pkg::scc_mode_t m);
        return m[2:1] == 2'b11;
    endfunction

    // ======================================================================
    // state
    logic [7:0]            trim_r,      trim_nxt;
    logic                  iosc_on_r,   iosc_on_nxt;
    logic [1:0]            idiv_r,      idiv_nxt;
    logic [SW-1:0]         settle_r,    settle_nxt;
    scc_pkg::scc_mode_t    mode_r,      mode_nxt;
    logic [2:0]            drive_r,     drive_nxt;
    logic [XW-1:0]         xcnt_r,      xcnt_nxt;
    logic                  half_r,      half_nxt;
    logic                  ext_eff_r,   ext_eff_nxt;
    logic [1:0]            odiv_r,      odiv_nxt;
    scc_pkg::scc_src_t     req_r,       req_nxt;
    scc_pkg::scc_src_t     active_r,    active_nxt;
    logic                  core_r,      core_nxt;
    logic                  lock_r,      lock_nxt;
    logic [7:0]            rdata_r,     rdata_nxt;
    logic                  iosc_ready;
    logic                  xtal_valid;
    logic                  tick_req;
    logic                  tick_act;

    scc_div_if #(.W(2)) idiv_if ();
    scc_div_if #(.W(2)) odiv_if ();

    assign idiv_if.in_tick = iosc_on_r;
    assign idiv_if.shift   = 2'(2'd3 - idiv_r);
    assign odiv_if.in_tick = core_r;
    assign odiv_if.shift   = odiv_r;

    scc_clkdiv #(.MAXLOG(3)) u_idiv (
        .CLK     (CLK),
        .RESET_N (RESET_N),
        .d       (idiv_if.div)
    );

    scc_clkdiv #(.MAXLOG(3)) u_odiv (
        .CLK     (CLK),
        .RESET_N (RESET_N),
        .d       (odiv_if.div)
    );

    assign iosc_ready = iosc_on_r && (settle_r == SW'(IOSC_SETTLE));
    // the count only advances in crystal modes, so a stale count never shows
    assign xtal_valid = crystal_f(mode_r) && (xcnt_r == XW'(XTAL_SETTLE));

    function automatic logic src_tick(input scc_pkg::scc_src_t s, input logic ti,
                                      input logic te, input logic tp);
        unique case (s)
            scc_pkg::SCC_SRC_INT: return ti;
            scc_pkg::SCC_SRC_EXT: return te;
            scc_pkg::SCC_SRC_PLL: return tp;
            default:              return 1'b0;
        endcase
    endfunction

    assign tick_req = src_tick(req_r, idiv_if.out_tick, ext_eff_r, PLL_TICK);
    assign tick_act = src_tick(active_r, idiv_if.out_tick, ext_eff_r, PLL_TICK);

    // ======================================================================
    // next state
    always_comb begin
        trim_nxt    = trim_r;
        iosc_on_nxt = iosc_on_r;
        idiv_nxt    = idiv_r;
        mode_nxt    = mode_r;
        drive_nxt   = drive_r;
        odiv_nxt    = odiv_r;
        req_nxt     = req_r;
        active_nxt  = active_r;
        lock_nxt    = PLL_LOCK;
        if (SFR_WR) begin
            unique case (SFR_ADDR)
                `SCC_ADDR_TRIM: trim_nxt = SFR_WDATA;
                `SCC_ADDR_ICTL: begin
                    // enable and divider land together in one write
                    iosc_on_nxt = SFR_WDATA[`SCC_ICTL_ON_BIT];
                    idiv_nxt    = SFR_WDATA[1:0];
                end
                `SCC_ADDR_XCTL: begin
                    mode_nxt  = SFR_WDATA[6:4];
                    drive_nxt = SFR_WDATA[2:0];
                end
                `SCC_ADDR_SEL: begin
                    odiv_nxt = SFR_WDATA[5:4];
                    req_nxt  = scc_pkg::scc_src_t'(SFR_WDATA[1:0]);
                end
                default: ;
            endcase
        end
        // settle counter restarts whenever the oscillator is off
        if (!iosc_on_r) settle_nxt = '0;
        else if (settle_r != SW'(IOSC_SETTLE)) settle_nxt = SW'(settle_r + 1'b1);
        else settle_nxt = settle_r;
        if (!crystal_f(mode_r)) xcnt_nxt = '0;
        else if (EXT_OSC_TICK && xcnt_r != XW'(XTAL_SETTLE)) xcnt_nxt = XW'(xcnt_r + 1'b1);
        else xcnt_nxt = xcnt_r;
        half_nxt    = half_r;
        ext_eff_nxt = 1'b0;
        if (EXT_OSC_TICK && ext_on_f(mode_r)) begin
            half_nxt    = ext_half_f(mode_r) ? !half_r : 1'b0;
            ext_eff_nxt = !ext_half_f(mode_r) || half_r;
        end
        // software only asks for settled sources; the reserved code is ignored
        if (req_r != scc_pkg::SCC_SRC_RSV && req_r != active_r) begin
            core_nxt = tick_req;
            if (tick_req) active_nxt = req_r;
        end else begin
            core_nxt = tick_act;
        end
        rdata_nxt = 8'h00;
        unique case (SFR_ADDR)
            `SCC_ADDR_TRIM:  rdata_nxt = trim_r;
            `SCC_ADDR_ICTL:  rdata_nxt = {iosc_on_r, iosc_ready, 4'h0, idiv_r};
            `SCC_ADDR_XCTL:  rdata_nxt = {xtal_valid, mode_r, 1'b0, drive_r};
            `SCC_ADDR_SEL:   rdata_nxt = {2'b00, odiv_r, 2'b00, req_r};
            `SCC_ADDR_PLLST: rdata_nxt = {3'b000, lock_r, 4'h0};
            default:         rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            trim_r    <= TRIM_RESET;
            iosc_on_r <= 1'(`SCC_ICTL_RESET >> `SCC_ICTL_ON_BIT);
            idiv_r    <= 2'(`SCC_ICTL_RESET);
            settle_r  <= SW'(IOSC_SETTLE);
            mode_r    <= 3'(`SCC_XCTL_RESET >> 4);
            drive_r   <= 3'(`SCC_XCTL_RESET);
            xcnt_r    <= '0;
            half_r    <= 1'b0;
            ext_eff_r <= 1'b0;
            odiv_r    <= 2'(`SCC_SEL_RESET >> 4);
            req_r     <= scc_pkg::SCC_SRC_INT;
            active_r  <= scc_pkg::SCC_SRC_INT;
            core_r    <= 1'b0;
            lock_r    <= 1'b0;
            rdata_r   <= 8'h00;
        end else begin
            trim_r    <= trim_nxt;
            iosc_on_r <= iosc_on_nxt;
            idiv_r    <= idiv_nxt;
            settle_r  <= settle_nxt;
            mode_r    <= mode_nxt;
            drive_r   <= drive_nxt;
            xcnt_r    <= xcnt_nxt;
            half_r    <= half_nxt;
            ext_eff_r <= ext_eff_nxt;
            odiv_r    <= odiv_nxt;
            req_r     <= req_nxt;
            active_r  <= active_nxt;
            core_r    <= core_nxt;
            lock_r    <= lock_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // ======================================================================
    // outputs
    assign SFR_RDATA       = rdata_r;
    assign INT_OSC_TRIM    = trim_r;
    assign INT_OSC_ON      = iosc_on_r;
    assign EXT_OSC_MODE    = mode_r;
    assign EXT_DRIVE_RANGE = drive_r;
    assign EXT_OSC_ON      = ext_on_f(mode_r);
    assign CORE_CLK_EN     = core_r;
    assign CLK_OUT_EN      = odiv_if.out_tick;
    assign EXT_PERIPH_EN   = ext_eff_r;
    assign CORE_CLK_SOURCE = active_r;

    // ======================================================================
    // checks
    a_trim_write: assert property (@(posedge CLK) disable iff (!RESET_N)
        (SFR_WR && SFR_ADDR == `SCC_ADDR_TRIM) |=> INT_OSC_TRIM == $past(SFR_WDATA))
        else $error("trim write not stored");

    a_iosc_gate: assert property (@(posedge CLK) disable iff (!RESET_N)
        (SFR_WR && SFR_ADDR == `SCC_ADDR_ICTL) |=>
            INT_OSC_ON == $past(SFR_WDATA[7]) && idiv_r == $past(SFR_WDATA[1:0]))
        else $error("oscillator control write not taken whole");

    a_ready_start: assert property (@(posedge CLK) disable iff (!RESET_N)
        $rose(iosc_on_r) |-> !iosc_ready ##1 !iosc_ready)
        else $error("ready shown before settling");

    a_reset_source: assert property (@(posedge CLK)
        !RESET_N |=> CORE_CLK_SOURCE == 2'b00 && INT_OSC_ON)
        else $error("core not on internal oscillator after reset");

    a_reserved_src: assert property (@(posedge CLK) disable iff (!RESET_N)
        (req_r == scc_pkg::SCC_SRC_RSV) |=> $stable(CORE_CLK_SOURCE))
        else $error("reserved source code switched the core");

    a_switch_clean: assert property (@(posedge CLK) disable iff (!RESET_N)
        $changed(CORE_CLK_SOURCE) |-> CORE_CLK_EN)
        else $error("source changed between ticks");

    a_xvld_mode: assert property (@(posedge CLK) disable iff (!RESET_N)
        !crystal_f(mode_r) |=> xcnt_r == '0)
        else $error("stale crystal count kept outside crystal mode");

    a_bit3_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
        (SFR_ADDR == `SCC_ADDR_XCTL) |=> SFR_RDATA[3] == 1'b0)
        else $error("reserved bit reads nonzero");

    a_pll_flag: assert property (@(posedge CLK) disable iff (!RESET_N)
        (PLL_LOCK ##1 SFR_ADDR == `SCC_ADDR_PLLST) |=> SFR_RDATA[4])
        else $error("lock flag not shown");

    a_ext_periph: assert property (@(posedge CLK) disable iff (!RESET_N)
        (EXT_OSC_TICK && mode_r == 3'b010) |=> EXT_PERIPH_EN)
        else $error("external tick not passed to peripherals");
endmodule : scc_top

//--- testbench/scc_osc_model.sv
`timescale 1ns/1ns
// ========
// external oscillator and pll stand-in
module scc_osc_model #(
    parameter int EXT_PER  = 4,
    parameter int LOCK_DLY = 20
) (
    input  wire logic CLK,
    input  wire logic run_ext,
    input  wire logic run_pll,
    output logic      ext_tick,
    output logic      pll_tick,
    output logic      pll_lock
);
    int ec = 0;
    int lc = 0;
    initial begin
        ext_tick = 1'b0;
        pll_tick = 1'b0;
        pll_lock = 1'b0;
    end
    // ticks stand still while the driver is off, as a dead crystal would
    always @(posedge CLK) begin
        ec <= (run_ext && ec < EXT_PER - 1) ? ec + 1 : 0;
        ext_tick <= run_ext && ec == EXT_PER - 1;
        lc <= run_pll ? ((lc < LOCK_DLY) ? lc + 1 : lc) : 0;
        pll_lock <= run_pll && lc == LOCK_DLY;
        pll_tick <= pll_lock && !pll_tick;
    end
endmodule // scc_osc_model

//--- testbench/system_clock_source_control_bench.sv
`timescale 1ns/1ns
`include "scc_map.svh"
// ========
// clock source control bench
module system_clock_source_control_bench;
    logic       CLK = 1'b0, RESET_N = 1'b0, SFR_WR = 1'b0, pll_en = 1'b0, rd_flag = 1'b0;
    logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, rq[$], SFR_RDATA, INT_OSC_TRIM, v, e;
    logic [2:0] EXT_OSC_MODE, EXT_DRIVE_RANGE;
    logic [1:0] CORE_CLK_SOURCE;
    logic       INT_OSC_ON, EXT_OSC_ON, CORE_CLK_EN, CLK_OUT_EN, EXT_PERIPH_EN;
    logic       ext_t, pll_t, pll_l;
    logic [31:0] seed = 32'h000012fa;
    int         n_errors = 0, n_tests = 0, cyc = 0, c_core, c_out, c_ext, i;

    always #5 CLK = ~CLK;

    scc_top dut_u (.CLK(CLK), .RESET_N(RESET_N), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
        .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .EXT_OSC_TICK(ext_t),
        .PLL_TICK(pll_t), .PLL_LOCK(pll_l), .INT_OSC_TRIM(INT_OSC_TRIM),
        .INT_OSC_ON(INT_OSC_ON), .EXT_OSC_MODE(EXT_OSC_MODE),
        .EXT_DRIVE_RANGE(EXT_DRIVE_RANGE), .EXT_OSC_ON(EXT_OSC_ON),
        .CORE_CLK_EN(CORE_CLK_EN), .CLK_OUT_EN(CLK_OUT_EN),
        .EXT_PERIPH_EN(EXT_PERIPH_EN), .CORE_CLK_SOURCE(CORE_CLK_SOURCE));
    scc_osc_model osc_u (.CLK(CLK), .run_ext(EXT_OSC_ON), .run_pll(pll_en),
        .ext_tick(ext_t), .pll_tick(pll_t), .pll_lock(pll_l));

    // ========
    // helpers
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK);
        SFR_ADDR <= a;
        SFR_WR <= 1'b1;
        SFR_WDATA <= d;
        @(negedge CLK);
        SFR_WR <= 1'b0;
    endtask
    // read data is registered, so the note is checked one edge after the address
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(negedge CLK);
        SFR_ADDR <= a;
        rd_flag <= 1'b1;
        rq.push_back(x);
        @(negedge CLK);
        rd_flag <= 1'b0;
    endtask
    task automatic cnt(input int n);
        c_core = 0;
        c_out = 0;
        c_ext = 0;
        repeat (n) begin
            @(negedge CLK);
            c_core += (CORE_CLK_EN === 1'b1);
            c_out += (CLK_OUT_EN === 1'b1);
            c_ext += (EXT_PERIPH_EN === 1'b1);
        end
    endtask
    task automatic wsrc(input logic [1:0] s);
        repeat (64) if (CORE_CLK_SOURCE !== s) @(negedge CLK);
        chk(8'(CORE_CLK_SOURCE), 8'(s), "source");
    endtask
    task results;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    always @(negedge CLK) if (rd_flag === 1'b1) chk(SFR_RDATA, rq.pop_front(), "read");
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_errors++;
            $display("[ERR] %0t timeout", $time);
            results();
        end
    end

    // ========
    // main sequence
    initial begin
        repeat (12) @(negedge CLK);
        RESET_N <= 1'b1;
        rd(`SCC_ADDR_ICTL, `SCC_ICTL_RESET);
        rd(`SCC_ADDR_TRIM, `SCC_TRIM_RESET);
        rd(`SCC_ADDR_XCTL, `SCC_XCTL_RESET);
        rd(`SCC_ADDR_SEL, `SCC_SEL_RESET);
        wr(8'h8e, 8'hff);
        rd(8'h8e, 8'h00);
        chk(8'(CORE_CLK_SOURCE), 8'h00, "reset source");
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            v = rnd();
            wr(`SCC_ADDR_TRIM, v);
            rd(`SCC_ADDR_TRIM, v);
            chk(INT_OSC_TRIM, v, "trim out");
        end
        $display("test trim done");
        // enable and divider go in one write each time
        for (i = 0; i < 4; i++) begin
            wr(`SCC_ADDR_ICTL, 8'h80 | 8'(i));
            repeat (16) @(negedge CLK);
            cnt(64);
            chk(8'(c_core), 8'(64 >> (3 - i)), "int div");
            rd(`SCC_ADDR_ICTL, 8'hc0 | 8'(i));
        end
        $display("test int divider done");
        for (i = 0; i < 4; i++) begin
            wr(`SCC_ADDR_SEL, 8'(i << 4));
            repeat (16) @(negedge CLK);
            cnt(64);
            chk(8'(c_out), 8'(64 >> i), "clock out");
            rd(`SCC_ADDR_SEL, 8'(i << 4));
        end
        wr(`SCC_ADDR_SEL, 8'h00);
        $display("test clock out done");
        wr(`SCC_ADDR_ICTL, 8'h03);
        rd(`SCC_ADDR_ICTL, 8'h03);
        chk(8'(INT_OSC_ON), 8'h00, "osc off");
        wr(`SCC_ADDR_ICTL, 8'h83);
        rd(`SCC_ADDR_ICTL, 8'h83);
        chk(8'(INT_OSC_ON), 8'h01, "osc on");
        repeat (`SCC_IOSC_SETTLE) @(negedge CLK);
        rd(`SCC_ADDR_ICTL, 8'hc3);
        $display("test osc enable done");
        // bits 7 and 3 written as ones must not stick
        for (i = 0; i < 8; i++) begin
            e = rnd() & 8'h07;
            wr(`SCC_ADDR_XCTL, 8'(i << 4) | e | 8'h88);
            repeat (16) @(negedge CLK);
            chk({5'h00, EXT_OSC_MODE}, 8'(i), "mode");
            chk({5'h00, EXT_DRIVE_RANGE}, e, "range");
            chk(8'(EXT_OSC_ON), 8'(i > 1), "ext on");
            cnt(64);
            chk(8'(c_ext), (i < 2) ? 8'h00 : (i == 2 || i == 6) ? 8'h10 : 8'h08, "periph");
            if (i < 6) rd(`SCC_ADDR_XCTL, 8'(i << 4) | e);
        end
        $display("test ext modes done");
        // leave crystal mode first so the settle count really starts from zero
        wr(`SCC_ADDR_XCTL, 8'h00);
        wr(`SCC_ADDR_XCTL, 8'h67);
        rd(`SCC_ADDR_XCTL, 8'h67);
        repeat (4 * `SCC_XTAL_SETTLE + 16) @(negedge CLK);
        rd(`SCC_ADDR_XCTL, 8'he7);
        wr(`SCC_ADDR_SEL, 8'h01);
        wsrc(2'b01);
        cnt(64);
        chk(8'(c_core), 8'h10, "ext core");
        $display("test crystal done");
        rd(`SCC_ADDR_PLLST, 8'h00);
        pll_en <= 1'b1;
        repeat (40) @(negedge CLK);
        rd(`SCC_ADDR_PLLST, 8'h10);
        wr(`SCC_ADDR_SEL, 8'h02);
        wsrc(2'b10);
        cnt(64);
        chk(8'(c_core), 8'h20, "pll core");
        wr(`SCC_ADDR_SEL, 8'h03);
        repeat (32) @(negedge CLK);
        chk(8'(CORE_CLK_SOURCE), 8'h02, "reserved");
        rd(`SCC_ADDR_SEL, 8'h03);
        wr(`SCC_ADDR_SEL, 8'h00);
        wsrc(2'b00);
        $display("test pll done");
        results();
    end
endmodule // system_clock_source_control_bench
